// [shared/ddr2_cmd_defines.vh]
// Constants for the DDR2 command, init and mode register block.
// Assumes inclusion by bare name from the design files.
// Functional notes
// - Decode CS, RAS, CAS, WE into commands
// - A10 picks all-bank or auto precharge
// - CKE edges enter and leave power states
// - Commands need CKE high twice running
// - Byte masks discard write data per lane
// - Activate opens row A0-A12 in bank
// - Bursts of four or eight after activate
// - Mode register undefined until first programmed
// - A2:A0 burst length, A3 burst order
// - A6:A4 give the read latency
// - Self refresh stops DLL, exit restarts it
`ifndef DDR2_CMD_DEFINES_VH
`define DDR2_CMD_DEFINES_VH

// Command codes as {cs, ras, cas, we}
`define CMD_MODE_WRITE 4'h0
`define CMD_REFRESH 4'h1
`define CMD_PRECHARGE 4'h2
`define CMD_ACTIVATE 4'h3
`define CMD_WRITE 4'h4
`define CMD_READ 4'h5
`define CMD_NOP 4'h7

// Mode register fields
`define MR_WIDTH 13
`define MR_RESET 13'h0000
`define MR_BL_MSB 2
`define MR_BL_LSB 0
`define MR_ORDER_BIT 3
`define MR_CL_MSB 6
`define MR_CL_LSB 4
`define MR_TEST_BIT 7
`define MR_DLL_RESET_BIT 8
`define MR_WR_MSB 11
`define MR_WR_LSB 9
`define BL_FOUR 3'h2
`define BL_EIGHT 3'h3

// Extended register 1 fields
`define EMR_DLL_OFF_BIT 0
`define EMR_CAL_MSB 9
`define EMR_CAL_LSB 7

// Register select by bank bits {bank1, bank0}
`define SEL_MODE 2'h0
`define SEL_EXT1 2'h1

// Address bit for all-bank and auto precharge
`define AP_BIT 10

// DLL lock time in link clocks
`define DLL_LOCK_CLOCKS 8'hC8

`endif

// [hdl/pin_sync.v]
// Two-stage synchroniser for a group of pin inputs.
// Assumes pins change slowly against core_clk_in.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 1
) (
   input wire core_clk_in, // Core clock
   input wire rst_b_in, // Async reset, low
   input wire en_in, // Clock enable
   input wire [WIDTH-1:0] pins_in, // Raw pin levels
   output reg [WIDTH-1:0] pins_out // Synchronised levels
);
   reg [WIDTH-1:0] meta_q;

   // First stage feeds only the second
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_q <= {WIDTH{1'b0}};
         pins_out <= {WIDTH{1'b0}};
      end else if (en_in) begin
         meta_q <= pins_in;
         pins_out <= meta_q;
      end
   end
endmodule // pin_sync
`default_nettype wire

// [hdl/open_row_mem.v]
// Open-row table, one entry per bank, registered read.
// Assumes one write and one read address per cycle.
`timescale 1ns/10ps
`default_nettype none
module open_row_mem #(
   parameter DEPTH_LOG2 = 2,
   parameter WIDTH = 13
) (
   input wire core_clk_in, // Core clock
   input wire rst_b_in, // Async reset, low
   input wire en_in, // Clock enable
   input wire wr_en_in, // Write strobe
   input wire [DEPTH_LOG2-1:0] wr_addr_in, // Write bank
   input wire [WIDTH-1:0] wr_data_in, // Row to store
   input wire [DEPTH_LOG2-1:0] rd_addr_in, // Read bank
   output reg [WIDTH-1:0] rd_data_out // Stored row
);
   reg [WIDTH-1:0] mem_q [0:(1<<DEPTH_LOG2)-1];
   integer i;

   // Rows survive until overwritten; reset clears them
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (i = 0; i < (1<<DEPTH_LOG2); i = i + 1) begin
            mem_q[i] <= {WIDTH{1'b0}};
         end
         rd_data_out <= {WIDTH{1'b0}};
      end else if (en_in) begin
         if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
         end
         rd_data_out <= mem_q[rd_addr_in];
      end
   end
endmodule // open_row_mem
`default_nettype wire

// [hdl/ddr2_cmd_core.v]
// Command decode, power states, mode register and burst walk.
// Assumes link pins sampled by core_clk_in, link clock much slower.
`timescale 1ns/10ps
`default_nettype none
`include "ddr2_cmd_defines.vh"
module ddr2_cmd_core (
   input wire core_clk_in, // 100 MHz core clock
   input wire rst_b_in, // Async reset, low
   input wire en_in, // Clock enable, freezes all
   input wire link_clk_in, // Link clock pin
   input wire cke_in, // Link clock enable
   input wire cs_b_in, // Chip select, low
   input wire row_strobe_b_in, // Row strobe, low
   input wire col_strobe_b_in, // Column strobe, low
   input wire write_en_b_in, // Write enable, low
   input wire bank_select_bit0_in, // Bank bit 0
   input wire bank_select_bit1_in, // Bank bit 1
   input wire [12:0] addr_in, // Address bus
   input wire lower_byte_mask_in, // Mask for data 7:0
   input wire upper_byte_mask_in, // Mask for data 15:8
   input wire on_die_termination_input_in, // Termination
   input wire [15:0] dq_in, // Write data
   output reg [12:0] mode_reg_out, // Mode register
   output reg mode_valid_out, // Mode programmed
   output reg [2:0] read_latency_out, // Read latency
   output reg [2:0] write_recovery_out, // Write recovery
   output reg [2:0] driver_cal_out, // Calibration field
   output reg dll_ready_out, // DLL locked
   output reg [1:0] power_state_out, // Power state
   output reg [3:0] open_banks_out, // Banks with open row
   output reg beat_valid_out, // One burst beat
   output reg beat_write_out, // Beat is a write
   output reg [1:0] beat_bank_out, // Beat bank
   output reg [9:0] beat_col_out, // Beat column
   output reg [12:0] beat_row_out, // Beat row
   output reg [15:0] wr_data_out, // Write data
   output reg [1:0] wr_byte_en_out, // Lanes kept
   output reg termination_en_out, // Termination level
   output reg access_error_out // Refused command
);
   localparam PS_ACTIVE = 2'h0;
   localparam PS_POWERDOWN = 2'h1;
   localparam PS_SELFREF = 2'h2;
   localparam NPIN = 40;

   wire [NPIN-1:0] pins_s;
   wire ck_s;
   wire cke_s;
   wire [3:0] cmd;
   wire [1:0] bank_s;
   wire [12:0] addr_s;
   wire [1:0] mask_s;
   wire [15:0] dq_s;
   wire odt_s;
   wire [12:0] row_rd;

   reg ck_prev_q;
   reg cke_prev_q;
   reg [1:0] ps_q;
   reg [12:0] mr_q;
   reg mr_valid_q;
   reg [2:0] cal_q;
   reg dll_on_q;
   reg [7:0] lock_cnt_q;
   reg [3:0] open_q;
   reg busy_q;
   reg [2:0] beat_q;
   reg [9:0] start_q;
   reg bl8_q;
   reg inter_q;
   reg wr_q;
   reg ap_q;
   reg [1:0] bbank_q;
   reg err_d;

   // Every pin, link clock included, is synchronised first
   pin_sync #(
      .WIDTH(NPIN)
   ) u_sync (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .en_in(en_in),
      .pins_in({link_clk_in, cke_in, cs_b_in, row_strobe_b_in,
         col_strobe_b_in, write_en_b_in, bank_select_bit1_in,
         bank_select_bit0_in, addr_in, upper_byte_mask_in,
         lower_byte_mask_in, on_die_termination_input_in,
         dq_in}),
      .pins_out(pins_s)
   );

   assign ck_s = pins_s[39];
   assign cke_s = pins_s[38];
   assign cmd = pins_s[37:34];
   assign bank_s = pins_s[33:32];
   assign addr_s = pins_s[31:19];
   assign mask_s = pins_s[18:17];
   assign odt_s = pins_s[16];
   assign dq_s = pins_s[15:0];

   // Link clock edges seen by the core clock
   wire ck_rise = ck_s & ~ck_prev_q;
   wire ck_fall = ~ck_s & ck_prev_q;
   wire nop_like = cmd[3] | (cmd == `CMD_NOP);
   wire cke_hh = cke_prev_q & cke_s;
   wire live = ck_rise & cke_hh & (ps_q == PS_ACTIVE);
   wire [2:0] bl_code = mr_q[`MR_BL_MSB:`MR_BL_LSB];
   wire bl_ok = (bl_code == `BL_FOUR) | (bl_code == `BL_EIGHT);
   wire bank_open = open_q[bank_s];
   wire is_act = live & (cmd == `CMD_ACTIVATE);
   wire is_pre = live & (cmd == `CMD_PRECHARGE);
   wire is_ref = live & (cmd == `CMD_REFRESH);
   wire is_mrw = live & (cmd == `CMD_MODE_WRITE);
   wire is_rw = live & ((cmd == `CMD_READ) | (cmd == `CMD_WRITE));
   // Unprogrammed register or closed bank refuses the access
   wire rw_ok = is_rw & bank_open & mr_valid_q & bl_ok;
   wire mrw_ok = is_mrw & (open_q == 4'h0);
   wire act_ok = is_act & ~bank_open;
   wire edge_any = ck_rise | ck_fall;
   wire beat_go = busy_q & edge_any & ~rw_ok;
   wire last_beat = bl8_q ? (beat_q == 3'h7) : (beat_q == 3'h3);
   wire dll_ready = dll_on_q & (lock_cnt_q == `DLL_LOCK_CLOCKS);

   // Column walk inside the aligned block of the burst
   wire [2:0] seq_low = start_q[2:0] + beat_q;
   wire [2:0] int_low = start_q[2:0] ^ beat_q;
   wire [2:0] low = inter_q ? int_low : seq_low;
   wire [9:0] col_now = bl8_q ? {start_q[9:3], low}
      : {start_q[9:2], low[1:0]};

   // Rows stored on activate, read back for the running burst
   open_row_mem #(
      .DEPTH_LOG2(2),
      .WIDTH(13)
   ) u_rows (
      .core_clk_in(core_clk_in),
      .rst_b_in(rst_b_in),
      .en_in(en_in),
      .wr_en_in(act_ok),
      .wr_addr_in(bank_s),
      .wr_data_in(addr_s),
      .rd_addr_in(bbank_q),
      .rd_data_out(row_rd)
   );

   // Refused command classes
   always @* begin
      err_d = 1'b0;
      if (is_rw & ~rw_ok) begin
         err_d = 1'b1;
      end
      if ((is_mrw & ~mrw_ok) | (is_act & ~act_ok)) begin
         err_d = 1'b1;
      end
      if (is_ref & (open_q != 4'h0)) begin
         err_d = 1'b1;
      end
      // Read before the DLL has settled still runs, but is flagged
      if (rw_ok & (cmd == `CMD_READ) & ~dll_ready) begin
         err_d = 1'b1;
      end
   end

   // Edge tracking and previous clock enable sample
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ck_prev_q <= 1'b0;
         cke_prev_q <= 1'b0;
      end else if (en_in) begin
         ck_prev_q <= ck_s;
         if (ck_rise) begin
            cke_prev_q <= cke_s;
         end
      end
   end

   // Power states follow clock enable transitions
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ps_q <= PS_ACTIVE;
      end else if (en_in & ck_rise) begin
         case (ps_q)
            PS_ACTIVE: begin
               if (cke_prev_q & ~cke_s) begin
                  if (cmd == `CMD_REFRESH && open_q == 4'h0) begin
                     ps_q <= PS_SELFREF;
                  end else if (nop_like) begin
                     ps_q <= PS_POWERDOWN;
                  end
               end
            end
            PS_POWERDOWN, PS_SELFREF: begin
               if (~cke_prev_q & cke_s & nop_like) begin
                  ps_q <= PS_ACTIVE;
               end
            end
            default: begin
               ps_q <= PS_ACTIVE;
            end
         endcase
      end
   end

   // Mode and extended register writes; other selects accepted
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mr_q <= `MR_RESET;
         mr_valid_q <= 1'b0;
         cal_q <= 3'h0;
      end else if (en_in & mrw_ok) begin
         if (bank_s == `SEL_MODE) begin
            mr_q <= addr_s;
            mr_valid_q <= 1'b1;
         end else if (bank_s == `SEL_EXT1) begin
            cal_q <= addr_s[`EMR_CAL_MSB:`EMR_CAL_LSB];
         end
      end
   end

   // DLL on, off and lock counted in link clocks
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         dll_on_q <= 1'b0;
         lock_cnt_q <= 8'h00;
      end else if (en_in & ck_rise) begin
         if (mrw_ok & (bank_s == `SEL_EXT1)) begin
            dll_on_q <= ~addr_s[`EMR_DLL_OFF_BIT];
            lock_cnt_q <= 8'h00;
         end else if (mrw_ok & (bank_s == `SEL_MODE)
               & addr_s[`MR_DLL_RESET_BIT]) begin
            lock_cnt_q <= 8'h00;
         end else if (ps_q == PS_ACTIVE & cke_prev_q & ~cke_s
               & cmd == `CMD_REFRESH & open_q == 4'h0) begin
            lock_cnt_q <= 8'h00;
         end else if (ps_q == PS_SELFREF) begin
            // Held stopped until exit, then counts afresh
            lock_cnt_q <= 8'h00;
         end else if (dll_on_q & ~dll_ready) begin
            lock_cnt_q <= lock_cnt_q + 8'h01;
         end
      end
   end

   // Bank open mask: activate, precharge, auto precharge
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         open_q <= 4'h0;
      end else if (en_in) begin
         // Auto precharge kept when an activate or precharge lands alongside; a new read or write drops it
         if (beat_go & last_beat & ap_q) begin
            open_q[bbank_q] <= 1'b0;
         end
         if (act_ok) begin
            open_q[bank_s] <= 1'b1;
         end else if (is_pre) begin
            if (addr_s[`AP_BIT]) begin
               open_q <= 4'h0;
            end else begin
               open_q[bank_s] <= 1'b0;
            end
         end
      end
   end

   // Burst engine: beats on both link edges after the command
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_q <= 1'b0;
         beat_q <= 3'h0;
         start_q <= 10'h000;
         bl8_q <= 1'b0;
         inter_q <= 1'b0;
         wr_q <= 1'b0;
         ap_q <= 1'b0;
         bbank_q <= 2'h0;
      end else if (en_in) begin
         if (rw_ok) begin
            // A new access cuts off any burst still running
            busy_q <= 1'b1;
            beat_q <= 3'h0;
            start_q <= addr_s[9:0];
            bl8_q <= (bl_code == `BL_EIGHT);
            inter_q <= mr_q[`MR_ORDER_BIT];
            wr_q <= (cmd == `CMD_WRITE);
            ap_q <= addr_s[`AP_BIT];
            bbank_q <= bank_s;
         end else if (beat_go) begin
            beat_q <= beat_q + 3'h1;
            if (last_beat) begin
               busy_q <= 1'b0;
            end
         end
      end
   end

   // Beat outputs; row comes from the table one cycle later
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         beat_valid_out <= 1'b0;
         beat_write_out <= 1'b0;
         beat_bank_out <= 2'h0;
         beat_col_out <= 10'h000;
         beat_row_out <= 13'h0000;
         wr_data_out <= 16'h0000;
         wr_byte_en_out <= 2'h0;
      end else if (en_in) begin
         beat_valid_out <= beat_go;
         beat_row_out <= row_rd;
         if (beat_go) begin
            beat_write_out <= wr_q;
            beat_bank_out <= bbank_q;
            beat_col_out <= col_now;
            wr_data_out <= dq_s;
            // Lanes with mask high are dropped
            wr_byte_en_out <= wr_q ? ~mask_s : 2'h0;
         end
      end
   end

   // Status outputs
   always @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mode_reg_out <= `MR_RESET;
         mode_valid_out <= 1'b0;
         read_latency_out <= 3'h0;
         write_recovery_out <= 3'h0;
         driver_cal_out <= 3'h0;
         dll_ready_out <= 1'b0;
         power_state_out <= PS_ACTIVE;
         open_banks_out <= 4'h0;
         termination_en_out <= 1'b0;
         access_error_out <= 1'b0;
      end else if (en_in) begin
         mode_reg_out <= mr_q;
         mode_valid_out <= mr_valid_q;
         read_latency_out <= mr_q[`MR_CL_MSB:`MR_CL_LSB];
         write_recovery_out <= mr_q[`MR_WR_MSB:`MR_WR_LSB];
         driver_cal_out <= cal_q;
         dll_ready_out <= dll_ready;
         power_state_out <= ps_q;
         open_banks_out <= open_q;
         termination_en_out <= odt_s;
         access_error_out <= err_d;
      end
   end
endmodule // ddr2_cmd_core
`default_nettype wire

// [test/ddr2_cmd_core_props.sv]
// Timing checks on the command, init and mode register block.
// Assumes a bind to ddr2_cmd_core and a link clock far below the core clock.
`timescale 1ns/10ps
`default_nettype none
module ddr2_cmd_core_props (
   input wire core_clk_in, // Core clock
   input wire rst_b_in, // Async reset, low
   input wire link_clk_in, // Link clock pin
   input wire [12:0] mode_reg_out, // Mode register
   input wire mode_valid_out, // Mode programmed
   input wire [2:0] read_latency_out, // Read latency
   input wire [2:0] write_recovery_out, // Write recovery
   input wire dll_ready_out, // DLL locked
   input wire [1:0] power_state_out, // Power state
   input wire [3:0] open_banks_out, // Banks with open row
   input wire beat_valid_out, // Beat strobe
   input wire beat_write_out, // Beat is a write
   input wire [1:0] beat_bank_out, // Beat bank
   input wire access_error_out // Refused command
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rst_b_in);

   // Refusals come from a command taken on a link rise, one cycle each
   a_error_one_cycle: assert property (access_error_out |=> !access_error_out)
      else $error("refusal strobe longer than one cycle");
   a_error_on_rise: assert property ($rose(access_error_out) |-> link_clk_in)
      else $error("refusal not tied to a link rising edge");
   // Beats follow link edges, so at least five idle cycles between them
   a_beat_gap: assert property (beat_valid_out |=> !beat_valid_out [*5])
      else $error("burst beats closer than a link half period");
   a_beat_bank_open: assert property (beat_valid_out |-> open_banks_out[beat_bank_out])
      else $error("beat on a bank with no open row");
   // Accesses only once the mode register holds a value
   a_beat_mode_set: assert property (beat_valid_out |-> mode_valid_out)
      else $error("beat before mode register written");
   a_valid_sticks: assert property (mode_valid_out |=> mode_valid_out)
      else $error("mode valid dropped without reset");
   // Mode register only changes while every bank is precharged
   a_mode_when_idle: assert property (!$stable(mode_reg_out) |-> $past(open_banks_out) == 4'h0)
      else $error("mode register changed with a bank open");
   a_latency_field: assert property (read_latency_out == mode_reg_out[6:4])
      else $error("read latency differs from mode bits 6:4");
   a_recovery_field: assert property (write_recovery_out == mode_reg_out[11:9])
      else $error("write recovery differs from mode bits 11:9");
   // Settled self refresh keeps the DLL stopped
   a_selfref_dll: assert property ((power_state_out == 2'h2) [*2] |-> !dll_ready_out)
      else $error("DLL ready during self refresh");

   // Main scenarios reached
   cover property (beat_valid_out && beat_write_out);
   cover property (power_state_out == 2'h2);
   cover property (access_error_out);
endmodule // ddr2_cmd_core_props

bind ddr2_cmd_core ddr2_cmd_core_props i_ddr2_cmd_core_props (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .link_clk_in(link_clk_in),
   .mode_reg_out(mode_reg_out), .mode_valid_out(mode_valid_out),
   .read_latency_out(read_latency_out),
   .write_recovery_out(write_recovery_out), .dll_ready_out(dll_ready_out),
   .power_state_out(power_state_out), .open_banks_out(open_banks_out),
   .beat_valid_out(beat_valid_out), .beat_write_out(beat_write_out),
   .beat_bank_out(beat_bank_out), .access_error_out(access_error_out));
`default_nettype wire

// [test/ddr2_ctrl_model.sv]
// Behavioural memory controller driving every link pin of the block.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
`default_nettype none
`include "ddr2_cmd_defines.vh"
module ddr2_ctrl_model #(
   parameter POWERUP_NS = 200000 // Stable clock before clock enable
) (
   output logic link_clk_out, // Link clock
   output logic cke_out, // Link clock enable
   output logic [3:0] cmd_b_out, // {cs, ras, cas, we}
   output logic [1:0] bank_out, // {bit1, bit0}
   output logic [12:0] addr_out, // Address bus
   output logic [1:0] mask_out, // {upper, lower}
   output logic odt_out, // Termination pin
   output logic [15:0] dq_out // Write data
);
   // Memory clock runs free from power-up
   initial link_clk_out = 1'b0;
   always #62.5 link_clk_out = ~link_clk_out;

   // Power-up levels: enable and termination low
   initial begin
      cke_out = 1'b0;
      odt_out = 1'b0;
      cmd_b_out = 4'hF;
      bank_out = 2'h0;
      addr_out = 13'h0;
      mask_out = 2'h0;
      dq_out = 16'h0;
   end

   // One command on a rising edge, then deselect with a released bus
   task automatic issue(input logic cke, input logic [3:0] cmd,
                        input logic [1:0] bank, input logic [12:0] addr);
      @(negedge link_clk_out);
      #1;
      cke_out = cke;
      cmd_b_out = cmd;
      bank_out = bank;
      addr_out = addr;
      @(negedge link_clk_out);
      #1;
      cmd_b_out = 4'hF;
      bank_out = ~bank_out;
      addr_out = ~addr_out; // No stale value on a released bus
   endtask

   // Deselect cycles, address toggling so nothing stale looks valid
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge link_clk_out);
         #1;
         addr_out = ~addr_out;
      end
   endtask

   // Wait with enable low, then NOP only for the settling time
   task automatic power_up();
      #(POWERUP_NS);
      issue(1'b1, `CMD_NOP, 2'h0, 13'h0);
      idle(4);
   endtask

   // Data, masks and termination held until changed
   task automatic set_data(input logic [15:0] dq, input logic [1:0] mask,
                           input logic on_die_termination_input);
      dq_out = dq;
      mask_out = mask;
      odt_out = on_die_termination_input;
   endtask
endmodule // ddr2_ctrl_model
`default_nettype wire

// [test/tb_ddr2_cmd_core.sv]
// Self-checking bench for the command, init and mode register block.
// Assumes the controller model drives every link pin.
`timescale 1ns/10ps
`default_nettype none
`include "ddr2_cmd_defines.vh"
module tb_ddr2_cmd_core;
   logic clk, rst_b, en;
   wire lclk, cke, on_die_termination_input, mode_valid, dll_ready, beat_valid, beat_write;
   wire term_en, err;
   wire [3:0] cmd_b, open_banks;
   wire [1:0] bank, mask, pstate, beat_bank, byte_en;
   wire [12:0] addr, mode_reg, beat_row;
   wire [15:0] dq, wr_data;
   wire [2:0] rd_lat, wr_rec, cal;
   wire [9:0] beat_col;
   int n_mismatch = 0;
   int checks = 0;
   int n_err = 0;
   int n0 = 0;
   logic [2:0] bl;
   logic [9:0] cols[$];

   ddr2_ctrl_model i_ddr2_ctrl_model (.link_clk_out(lclk), .cke_out(cke),
      .cmd_b_out(cmd_b), .bank_out(bank), .addr_out(addr), .mask_out(mask),
      .odt_out(on_die_termination_input), .dq_out(dq));
   ddr2_cmd_core i_ddr2_cmd_core (.core_clk_in(clk), .rst_b_in(rst_b),
      .en_in(en), .link_clk_in(lclk), .cke_in(cke), .cs_b_in(cmd_b[3]),
      .row_strobe_b_in(cmd_b[2]), .col_strobe_b_in(cmd_b[1]),
      .write_en_b_in(cmd_b[0]), .bank_select_bit0_in(bank[0]),
      .bank_select_bit1_in(bank[1]), .addr_in(addr),
      .lower_byte_mask_in(mask[0]), .upper_byte_mask_in(mask[1]),
      .on_die_termination_input_in(on_die_termination_input), .dq_in(dq), .mode_reg_out(mode_reg),
      .mode_valid_out(mode_valid), .read_latency_out(rd_lat),
      .write_recovery_out(wr_rec), .driver_cal_out(cal),
      .dll_ready_out(dll_ready), .power_state_out(pstate),
      .open_banks_out(open_banks), .beat_valid_out(beat_valid),
      .beat_write_out(beat_write), .beat_bank_out(beat_bank),
      .beat_col_out(beat_col), .beat_row_out(beat_row),
      .wr_data_out(wr_data), .wr_byte_en_out(byte_en),
      .termination_en_out(term_en), .access_error_out(err));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   // Refusal strobes counted, beat columns queued as they pass
   always @(posedge clk) begin
      if (err === 1'b1) n_err++;
      if (beat_valid === 1'b1) cols.push_back(beat_col);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Refusals since the last call, then rebase
   task automatic errs(input int exp);
      check(16'(n_err - n0), 16'(exp));
      n0 = n_err;
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmd(input logic [3:0] c, input logic [1:0] b,
                      input logic [12:0] a);
      i_ddr2_ctrl_model.issue(1'b1, c, b, a);
   endtask

   // WR field 2 clocks, latency 3, test and DLL reset bits clear
   function automatic logic [12:0] mw(input logic [2:0] l, input logic ord);
      mw = {1'b0, 3'h1, 2'h0, 3'h3, ord, l};
   endfunction

   // One access, then the walked columns against the expected order
   task automatic burst(input logic [3:0] c, input logic [1:0] b,
                        input logic [12:0] a, input int n, input logic ilv);
      logic [9:0] m;
      m = (n == 8) ? 10'h7 : 10'h3;
      cols.delete();
      cmd(c, b, a);
      i_ddr2_ctrl_model.idle(5);
      check(16'(cols.size()), 16'(n));
      foreach (cols[i]) check(cols[i], ilv ? (a[9:0] & ~m) | ((a[9:0] ^ 10'(i)) & m) : (a[9:0] & ~m) | ((a[9:0] + 10'(i)) & m));
      if (n > 0) check(beat_bank, b);
   endtask

   // Hang guard
   initial begin
      #900000;
      n_mismatch++;
      complete_run();
   end

   initial begin
      rst_b = 1'b0;
      en = 1'b1;
      repeat (3) @(posedge clk);
      #1 rst_b = 1'b1;
      check(mode_valid, 1'b0);
      check(open_banks, 4'h0);
      $display("Test reset done");
      // Initialization with a refused access before the mode register is written
      i_ddr2_ctrl_model.power_up();
      cmd(`CMD_PRECHARGE, 2'h0, 13'h400);
      cmd(`CMD_MODE_WRITE, 2'h2, 13'h0);
      cmd(`CMD_MODE_WRITE, 2'h3, 13'h0);
      cmd(`CMD_MODE_WRITE, `SEL_EXT1, 13'h0);
      n0 = n_err;
      burst(`CMD_READ, 2'h0, 13'h5, 0, 1'b0);
      errs(1);
      cmd(`CMD_MODE_WRITE, `SEL_MODE, 13'h100);
      check(mode_reg, 13'h100);
      cmd(`CMD_PRECHARGE, 2'h0, 13'h400);
      cmd(`CMD_REFRESH, 2'h0, 13'h0);
      cmd(`CMD_REFRESH, 2'h0, 13'h0);
      cmd(`CMD_MODE_WRITE, `SEL_MODE, mw(`BL_FOUR, 1'b0));
      check(mode_valid, 1'b1);
      check(rd_lat, 3'h3);
      check(wr_rec, 3'h1);
      // Read before DLL lock is flagged but still performed
      cmd(`CMD_ACTIVATE, 2'h1, 13'h1ABC);
      check(open_banks, 4'h2);
      burst(`CMD_READ, 2'h1, 13'h5, 4, 1'b0);
      errs(1);
      check(beat_row, 13'h1ABC);
      cmd(`CMD_PRECHARGE, 2'h1, 13'h0);
      check(open_banks, 4'h0);
      i_ddr2_ctrl_model.idle(170);
      check(dll_ready, 1'b0);
      i_ddr2_ctrl_model.idle(25);
      check(dll_ready, 1'b1);
      cmd(`CMD_MODE_WRITE, `SEL_EXT1, 13'h380);
      check(cal, 3'h7);
      cmd(`CMD_MODE_WRITE, `SEL_EXT1, 13'h0);
      check(cal, 3'h0);
      // Extended writes restart the lock count
      i_ddr2_ctrl_model.idle(205);
      check(dll_ready, 1'b1);
      $display("Test init done");
      // Mode write refused with a bank open; others leave it alone
      cmd(`CMD_ACTIVATE, 2'h0, 13'h0FF);
      cmd(`CMD_MODE_WRITE, `SEL_MODE, mw(`BL_EIGHT, 1'b1));
      errs(1);
      check(mode_reg, mw(`BL_FOUR, 1'b0));
      burst(`CMD_WRITE, 2'h2, 13'h5, 0, 1'b0);
      errs(1);
      cmd(`CMD_PRECHARGE, 2'h0, 13'h400);
      cmd(`CMD_MODE_WRITE, 2'h2, 13'h1FFF);
      check(mode_reg, mw(`BL_FOUR, 1'b0));
      $display("Test refusal done");
      // Every length and order, auto precharge reads, masked writes
      for (int k = 0; k < 5; k++) begin
         bl = (k == 4) ? 3'h7 : (k[0] ? `BL_EIGHT : `BL_FOUR);
         cmd(`CMD_MODE_WRITE, `SEL_MODE, mw(bl, k[1]));
         cmd(`CMD_ACTIVATE, k[1:0], 13'h100 + 13'(k));
         burst(`CMD_READ, k[1:0], 13'h405, (k == 4) ? 0 : (k[0] ? 8 : 4), k[1]);
         errs(k == 4);
         check(open_banks, (k == 4) ? 4'h1 : 4'h0);
         if (k < 4) begin
            cmd(`CMD_ACTIVATE, k[1:0], 13'h7);
            i_ddr2_ctrl_model.set_data(16'hA5C3 ^ 16'(k), k[1:0], 1'b0);
            burst(`CMD_WRITE, k[1:0], 13'h0, k[0] ? 8 : 4, k[1]);
            check(beat_write, 1'b1);
            check(byte_en, {~k[1], ~k[0]});
            check(wr_data, 16'hA5C3 ^ 16'(k));
         end
         cmd(`CMD_PRECHARGE, 2'h0, 13'h400);
         check(open_banks, 4'h0);
      end
      $display("Test bursts done");
      // Power-down, ignored command while disabled, self refresh
      i_ddr2_ctrl_model.issue(1'b0, `CMD_NOP, 2'h0, 13'h0);
      check(pstate, 2'h1);
      i_ddr2_ctrl_model.issue(1'b0, `CMD_ACTIVATE, 2'h0, 13'h0);
      check(open_banks, 4'h0);
      i_ddr2_ctrl_model.issue(1'b1, `CMD_NOP, 2'h0, 13'h0);
      check(pstate, 2'h0);
      i_ddr2_ctrl_model.issue(1'b0, `CMD_REFRESH, 2'h0, 13'h0);
      check(pstate, 2'h2);
      check(dll_ready, 1'b0);
      i_ddr2_ctrl_model.issue(1'b1, `CMD_NOP, 2'h0, 13'h0);
      check(pstate, 2'h0);
      i_ddr2_ctrl_model.set_data(16'h0, 2'h0, 1'b1);
      i_ddr2_ctrl_model.idle(210);
      check(dll_ready, 1'b1);
      check(term_en, 1'b1);
      // Frozen core ignores a command
      @(posedge clk) #1 en = 1'b0;
      cmd(`CMD_ACTIVATE, 2'h3, 13'h0);
      @(posedge clk) #1 en = 1'b1;
      i_ddr2_ctrl_model.idle(1);
      check(open_banks, 4'h0);
      $display("Test power done");
      complete_run();
   end
endmodule // tb_ddr2_cmd_core
`default_nettype wire
